// ---- logic/cps_pin_select.sv ----
// Purpose : Selects the function of two configurable control pins.
// Assumes : APB slave with 32-bit data; pin inputs are asynchronous.
// Notes   : Every output comes straight from a flip-flop.
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
module cps_pin_select (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic [3:0]  nvm_code_a,
  input  wire logic [3:0]  nvm_code_b,
  input  wire logic        nvm_pull_down_en,
  input  wire logic        usb_configured,
  input  wire logic        usb_suspend,
  input  wire logic        charger_detected,
  input  wire logic        pin_toggle_write_strobe_n,
  input  wire logic        pin_toggle_read_strobe_n,
  input  wire logic        sof_received,
  input  wire logic        cable_unplugged,
  input  wire logic        config_pin_a_in,
  output logic             config_pin_a_out,
  output logic             config_pin_a_oe,
  output logic             config_pin_a_pull_down,
  input  wire logic        config_pin_b_in,
  output logic             config_pin_b_out,
  output logic             config_pin_b_oe,
  output logic             config_pin_b_pull_down,
  output logic             vbus_present,
  output logic             suspend_inhibit
);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Pin function table: returns output enable in bit 1 and level in bit 0.
  function automatic logic [1:0] pin_fn(
    input logic [3:0]                code,
    input logic                      configured,
    input logic                      suspend,
    input logic                      charger,
    input logic                      wr_n,
    input logic                      rd_n,
    input logic [cps_pkg::DIV_W-1:0] clks,
    input logic                      frame_tgl
  );
    logic [1:0] res;
    res = 2'h0;
    if (code == cps_pkg::FN_DRIVE_1) begin
      res = 2'h3;
    end else if (code == cps_pkg::FN_DRIVE_0) begin
      res = 2'h2;
    end else if (code == cps_pkg::FN_POWER_EN) begin
      res = {1'b1, ~(configured & ~suspend)};
    end else if (code == cps_pkg::FN_SLEEP) begin
      res = {1'b1, ~suspend};
    end else if (code == cps_pkg::FN_CLK_FAST) begin
      res = {1'b1, clks[0]};
    end else if (code == cps_pkg::FN_CLK_MID) begin
      res = {1'b1, clks[1]};
    end else if (code == cps_pkg::FN_CLK_SLOW) begin
      res = {1'b1, clks[2]};
    end else if (code == cps_pkg::FN_CHARGER) begin
      res = {1'b1, charger};
    end else if (code == cps_pkg::FN_CHARGER_N) begin
      res = {1'b1, ~charger};
    end else if (code == cps_pkg::FN_BB_WRITE) begin
      res = {1'b1, wr_n};
    end else if (code == cps_pkg::FN_BB_READ) begin
      res = {1'b1, rd_n};
    end else if (code == cps_pkg::FN_FRAME_TGL) begin
      res = {1'b1, frame_tgl};
    end else begin
      res = 2'h0;
    end
    return res;
  endfunction

  // Three-stage synchroniser with a filter that moves once stages two and three agree.
  function automatic logic filt(input logic s2, input logic s3, input logic cur);
    return (s2 == s3) ? s3 : cur;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////////
  // State.
  logic [3:0]                  code_a_ff;
  logic [3:0]                  code_b_ff;
  logic                        pull_dn_ff;
  logic                        load_pend_ff;
  logic [cps_pkg::EV_W-1:0]    irq_stat_ff;
  logic [cps_pkg::EV_W-1:0]    irq_mask_ff;
  logic [2:0]                  sync_a_ff;
  logic [2:0]                  sync_b_ff;
  logic                        lvl_a_ff;
  logic                        lvl_b_ff;
  logic                        frame_tgl_ff;
  logic                        suspend_d_ff;
  logic                        keep_awake_ff;
  logic                        vbus_ff;
  logic [31:0]                 prdata_ff;
  logic                        pready_ff;
  logic                        pslverr_ff;
  logic                        irq_ff;
  logic                        pin_a_out_ff;
  logic                        pin_a_oe_ff;
  logic                        pin_a_pd_ff;
  logic                        pin_b_out_ff;
  logic                        pin_b_oe_ff;
  logic                        pin_b_pd_ff;

  logic [cps_pkg::DIV_W-1:0]   clk_div;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Clock outputs, halted while the link is suspended.
  cps_clk_div u_clk_div (
    .pclk    (pclk),
    .presetn (presetn),
    .hold    (usb_suspend),
    .div_out (clk_div)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Pin functions.
  wire [1:0] fn_a = pin_fn(code_a_ff, usb_configured, usb_suspend, charger_detected,
                           pin_toggle_write_strobe_n, pin_toggle_read_strobe_n,
                           clk_div, frame_tgl_ff);
  wire [1:0] fn_b = pin_fn(code_b_ff, usb_configured, usb_suspend, charger_detected,
                           pin_toggle_write_strobe_n, pin_toggle_read_strobe_n,
                           clk_div, frame_tgl_ff);

  // Input-mode pins pull low during suspend when the option is set.
  wire       nxt_pd_a = ~fn_a[1] & pull_dn_ff & usb_suspend;
  wire       nxt_pd_b = ~fn_b[1] & pull_dn_ff & usb_suspend;

  // Filtered pin levels.
  wire       nxt_lvl_a = filt(sync_a_ff[1], sync_a_ff[2], lvl_a_ff);
  wire       nxt_lvl_b = filt(sync_b_ff[1], sync_b_ff[2], lvl_b_ff);

  // Bus power sense; pin A takes precedence when both pins select it.
  wire       vbus_sel_a = (code_a_ff == cps_pkg::FN_VBUS_SENSE);
  wire       vbus_sel_b = (code_b_ff == cps_pkg::FN_VBUS_SENSE);
  wire       nxt_vbus   = vbus_sel_a ? nxt_lvl_a :
                          vbus_sel_b ? nxt_lvl_b : cps_pkg::RST_VBUS;

  // Keep-awake is active while a selected pin is held low.
  wire       ka_a = (code_a_ff == cps_pkg::FN_KEEP_AWAKE) & ~nxt_lvl_a;
  wire       ka_b = (code_b_ff == cps_pkg::FN_KEEP_AWAKE) & ~nxt_lvl_b;
  wire       nxt_keep_awake = ka_a | ka_b;
  wire       nxt_inhibit    = nxt_keep_awake & cable_unplugged;

  wire       nxt_frame_tgl  = frame_tgl_ff ^ sof_received;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // APB decode; reads are captured in setup, answered in the first access cycle.
  wire       setup    = psel & ~penable;
  wire       access   = psel & penable & pready_ff;
  wire       hit_ctrl = (paddr == cps_pkg::OFS_CTRL);
  wire       hit_stat = (paddr == cps_pkg::OFS_STATUS);
  wire       hit_isr  = (paddr == cps_pkg::OFS_IRQ_STAT);
  wire       hit_imr  = (paddr == cps_pkg::OFS_IRQ_MASK);
  wire       hit_any  = hit_ctrl | hit_stat | hit_isr | hit_imr;
  wire       wr_ctrl  = access & pwrite & hit_ctrl;
  wire       wr_isr   = access & pwrite & hit_isr;
  wire       wr_imr   = access & pwrite & hit_imr;

  wire [31:0] ctrl_view = {23'h0, pull_dn_ff, code_b_ff, code_a_ff};
  wire [31:0] stat_view = {25'h0, lvl_b_ff, lvl_a_ff, keep_awake_ff, vbus_ff,
                           charger_detected, usb_suspend, usb_configured};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_view :
                       hit_stat ? stat_view :
                       hit_isr  ? {28'h0, irq_stat_ff} :
                       hit_imr  ? {28'h0, irq_mask_ff} : 32'h0;
  wire [31:0] nxt_prdata = setup ? rd_mux : prdata_ff;

  // Configuration: loaded once after reset, then writable over the bus.
  wire [3:0] nxt_code_a = load_pend_ff ? nvm_code_a :
                          wr_ctrl ? pwdata[cps_pkg::CTRL_CODE_A_LSB +: 4] : code_a_ff;
  wire [3:0] nxt_code_b = load_pend_ff ? nvm_code_b :
                          wr_ctrl ? pwdata[cps_pkg::CTRL_CODE_B_LSB +: 4] : code_b_ff;
  wire       nxt_pull_dn = load_pend_ff ? nvm_pull_down_en :
                           wr_ctrl ? pwdata[cps_pkg::CTRL_PULL_DN] : pull_dn_ff;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Interrupt events; a new event wins over a same-cycle clear.
  wire [cps_pkg::EV_W-1:0] events;
  assign events[cps_pkg::EV_VBUS_CHG]   = nxt_vbus != vbus_ff;
  assign events[cps_pkg::EV_KEEP_AWAKE] = nxt_keep_awake & ~keep_awake_ff;
  assign events[cps_pkg::EV_FRAME]      = sof_received;
  assign events[cps_pkg::EV_SUSPEND]    = usb_suspend & ~suspend_d_ff;

  wire [cps_pkg::EV_W-1:0] clr_mask     = wr_isr ? pwdata[cps_pkg::EV_W-1:0] : 4'h0;
  wire [cps_pkg::EV_W-1:0] nxt_irq_stat = (irq_stat_ff & ~clr_mask) | events;
  wire [cps_pkg::EV_W-1:0] nxt_irq_mask = wr_imr ? pwdata[cps_pkg::EV_W-1:0] : irq_mask_ff;
  wire                     nxt_irq      = |(nxt_irq_stat & nxt_irq_mask);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Configuration and register state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_pend_ff <= 1'b1;
      code_a_ff    <= cps_pkg::RST_CODE;
      code_b_ff    <= cps_pkg::RST_CODE;
      pull_dn_ff   <= 1'b0;
      irq_stat_ff  <= 4'h0;
      irq_mask_ff  <= cps_pkg::RST_IRQ_MASK;
    end else begin
      load_pend_ff <= 1'b0;
      code_a_ff    <= nxt_code_a;
      code_b_ff    <= nxt_code_b;
      pull_dn_ff   <= nxt_pull_dn;
      irq_stat_ff  <= nxt_irq_stat;
      irq_mask_ff  <= nxt_irq_mask;
    end
  end

  // Bus answer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff  <= nxt_prdata;
      pready_ff  <= setup;
      pslverr_ff <= setup & ~hit_any;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Pin input synchronisers and sensed levels.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a_ff     <= 3'h7;
      sync_b_ff     <= 3'h7;
      lvl_a_ff      <= 1'b1;
      lvl_b_ff      <= 1'b1;
      vbus_ff       <= cps_pkg::RST_VBUS;
      keep_awake_ff <= 1'b0;
      suspend_d_ff  <= 1'b0;
      frame_tgl_ff  <= 1'b0;
    end else begin
      sync_a_ff     <= {sync_a_ff[1:0], config_pin_a_in};
      sync_b_ff     <= {sync_b_ff[1:0], config_pin_b_in};
      lvl_a_ff      <= nxt_lvl_a;
      lvl_b_ff      <= nxt_lvl_b;
      vbus_ff       <= nxt_vbus;
      keep_awake_ff <= nxt_keep_awake;
      suspend_d_ff  <= usb_suspend;
      frame_tgl_ff  <= nxt_frame_tgl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Registered pin drivers and system outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_a_out_ff    <= 1'b0;
      pin_a_oe_ff     <= 1'b0;
      pin_a_pd_ff     <= 1'b0;
      pin_b_out_ff    <= 1'b0;
      pin_b_oe_ff     <= 1'b0;
      pin_b_pd_ff     <= 1'b0;
      irq_ff          <= 1'b0;
      suspend_inhibit <= 1'b0;
    end else begin
      pin_a_out_ff    <= fn_a[0];
      pin_a_oe_ff     <= fn_a[1];
      pin_a_pd_ff     <= nxt_pd_a;
      pin_b_out_ff    <= fn_b[0];
      pin_b_oe_ff     <= fn_b[1];
      pin_b_pd_ff     <= nxt_pd_b;
      irq_ff          <= nxt_irq;
      suspend_inhibit <= nxt_inhibit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Port connections.
  assign prdata                 = prdata_ff;
  assign pready                 = pready_ff;
  assign pslverr                = pslverr_ff;
  assign irq                    = irq_ff;
  assign config_pin_a_out       = pin_a_out_ff;
  assign config_pin_a_oe        = pin_a_oe_ff;
  assign config_pin_a_pull_down = pin_a_pd_ff;
  assign config_pin_b_out       = pin_b_out_ff;
  assign config_pin_b_oe        = pin_b_oe_ff;
  assign config_pin_b_pull_down = pin_b_pd_ff;
  assign vbus_present           = vbus_ff;

endmodule

// ---- logic/cps_pkg.sv ----
// Purpose : Shared constants for the configurable control pin function selector.
// Assumes : One clock (pclk) and an active-low asynchronous reset (presetn).
// Notes   : Register offsets are byte addresses on a 32-bit APB slave.
package cps_pkg;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Function codes held in the configuration register, four bits per pin.
  localparam logic [3:0] FN_TRISTATE   = 4'h0;
  localparam logic [3:0] FN_DRIVE_1    = 4'h1;
  localparam logic [3:0] FN_DRIVE_0    = 4'h2;
  localparam logic [3:0] FN_POWER_EN   = 4'h3;
  localparam logic [3:0] FN_SLEEP      = 4'h4;
  localparam logic [3:0] FN_CLK_FAST   = 4'h5;
  localparam logic [3:0] FN_CLK_MID    = 4'h6;
  localparam logic [3:0] FN_CLK_SLOW   = 4'h7;
  localparam logic [3:0] FN_CHARGER    = 4'h8;
  localparam logic [3:0] FN_CHARGER_N  = 4'h9;
  localparam logic [3:0] FN_BB_WRITE   = 4'hA;
  localparam logic [3:0] FN_BB_READ    = 4'hB;
  localparam logic [3:0] FN_VBUS_SENSE = 4'hC;
  localparam logic [3:0] FN_FRAME_TGL  = 4'hD;
  localparam logic [3:0] FN_KEEP_AWAKE = 4'hE;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h0C;

  // Control register fields.
  localparam int         CTRL_CODE_A_LSB = 0;
  localparam int         CTRL_CODE_B_LSB = 4;
  localparam int         CTRL_PULL_DN    = 8;

  // Status register fields.
  localparam int         ST_CONFIGURED = 0;
  localparam int         ST_SUSPEND    = 1;
  localparam int         ST_CHARGER    = 2;
  localparam int         ST_VBUS       = 3;
  localparam int         ST_KEEP_AWAKE = 4;
  localparam int         ST_PIN_A      = 5;
  localparam int         ST_PIN_B      = 6;

  // Interrupt event bits.
  localparam int         EV_VBUS_CHG   = 0;
  localparam int         EV_KEEP_AWAKE = 1;
  localparam int         EV_FRAME      = 2;
  localparam int         EV_SUSPEND    = 3;
  localparam int         EV_W          = 4;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [3:0]      RST_CODE     = 4'h0;
  localparam logic [EV_W-1:0] RST_IRQ_MASK = 4'h0;
  localparam logic            RST_VBUS     = 1'b1;

  // Clock divider: core clock and the three division ratios.
  localparam int         CORE_CLK_MHZ  = 48;
  localparam int         DIV_FAST      = 2;
  localparam int         DIV_MID       = 4;
  localparam int         DIV_SLOW      = 8;
  localparam int         DIV_W         = 3;

endpackage

// ---- logic/cps_clk_div.sv ----
// Purpose : Divides the core clock by 2, 4 and 8 with fifty percent duty.
// Assumes : Runs from the same clock as the selector.
// Notes   : The count freezes while hold is high, so all outputs stop.
`timescale 1ns/10ps
module cps_clk_div (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     hold,
  output logic [cps_pkg::DIV_W-1:0]     div_out
);

  logic [cps_pkg::DIV_W-1:0] cnt_ff;
  logic [cps_pkg::DIV_W-1:0] nxt_cnt;

  // Bit n of a free count toggles every 2**n cycles, a division by 2**(n+1).
  assign nxt_cnt = hold ? cnt_ff : cnt_ff + 3'h1;
  assign div_out = cnt_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 3'h0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule

// ---- dv/cps_pin_select_sva.sv ----
// Purpose: Port checker for the pin function selector.
// Assumes: Pin A codes change only at load and by CTRL writes.
// Notes: Bound to the selector at the foot of this file.
`timescale 1ns/10ps
module cps_pin_select_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  nvm_code_a,
  input wire logic        usb_configured,
  input wire logic        usb_suspend,
  input wire logic        charger_detected,
  input wire logic        pin_toggle_write_strobe_n,
  input wire logic        sof_received,
  input wire logic        cable_unplugged,
  input wire logic        config_pin_a_out,
  input wire logic        config_pin_a_oe,
  input wire logic        config_pin_a_pull_down,
  input wire logic        suspend_inhibit
);
  logic [3:0] code_ff;
  logic       ld_ff;
  wire        ctrl_wr = psel && penable && pready && pwrite && paddr == cps_pkg::OFS_CTRL;
  wire        clk_fn  = code_ff >= 4'h5 && code_ff <= 4'h7;

  // Mirrors the pin A function code.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ld_ff   <= 1'h0;
      code_ff <= 4'h0;
    end else if (!ld_ff || ctrl_wr) begin
      ld_ff   <= 1'h1;
      code_ff <= ld_ff ? pwdata[3:0] : nvm_code_a;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready is not one access cycle");
  a_err_unmapped: assert property (psel && !penable && !pwrite && paddr > 8'h0C
    |=> pslverr && prdata == 32'h0) else $error("unmapped read not refused");
  a_drive_const: assert property ($past(ld_ff) && $past(code_ff) inside {4'h1, 4'h2}
    |-> config_pin_a_oe && config_pin_a_out == ($past(code_ff) == 4'h1))
    else $error("constant level wrong");
  a_tri_input: assert property ($past(ld_ff) && $past(code_ff) inside {4'h0, 4'hC, 4'hE, 4'hF}
    |-> !config_pin_a_oe) else $error("input pin driven");
  a_power_enable: assert property ($past(ld_ff) && $past(code_ff) == 4'h3
    |-> config_pin_a_out == !($past(usb_configured) && !$past(usb_suspend)))
    else $error("power enable level wrong");
  a_sleep_level: assert property ($past(ld_ff) && $past(code_ff) == 4'h4
    |-> config_pin_a_out == !$past(usb_suspend)) else $error("sleep level wrong");
  a_charger_out: assert property ($past(ld_ff) && $past(code_ff) inside {4'h8, 4'h9}
    |-> config_pin_a_out == ($past(charger_detected) ^ ($past(code_ff) == 4'h9)))
    else $error("charger level wrong");
  a_strobe_write: assert property ($past(ld_ff) && $past(code_ff) == 4'hA
    |-> config_pin_a_out == $past(pin_toggle_write_strobe_n)) else $error("strobe wrong");
  a_clk_fast: assert property ((code_ff == 4'h5 && !usb_suspend)[*4]
    |=> config_pin_a_out != $past(config_pin_a_out)) else $error("fast clock stalled");
  a_clk_freeze: assert property ((clk_fn && usb_suspend)[*5]
    |=> $stable(config_pin_a_out)) else $error("clock runs in suspend");
  a_frame_toggle: assert property ($past(ld_ff, 2) && $past(code_ff) == 4'hD
    && $past(code_ff, 2) == 4'hD |-> config_pin_a_out ==
    ($past(config_pin_a_out) ^ $past(sof_received, 2))) else $error("frame toggle wrong");
  a_inhibit_cause: assert property (suspend_inhibit |-> $past(cable_unplugged))
    else $error("inhibit without unplug");
  a_pull_low: assert property (config_pin_a_pull_down
    |-> !config_pin_a_oe && $past(usb_suspend)) else $error("pull-down out of suspend");
endmodule

bind cps_pin_select cps_pin_select_sva u_sva (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .nvm_code_a(nvm_code_a), .usb_configured(usb_configured), .usb_suspend(usb_suspend),
  .charger_detected(charger_detected), .pin_toggle_write_strobe_n(pin_toggle_write_strobe_n),
  .sof_received(sof_received), .cable_unplugged(cable_unplugged),
  .config_pin_a_out(config_pin_a_out), .config_pin_a_oe(config_pin_a_oe),
  .config_pin_a_pull_down(config_pin_a_pull_down), .suspend_inhibit(suspend_inhibit)
);

// ---- dv/cps_board_model.sv ----
// Purpose: Board side of one configurable pin.
// Assumes: A weak pull-up on the pad unless the device pulls it low.
// Notes: The bench decides when the board drives.
`timescale 1ns/10ps
module cps_board_model (
  input  wire logic oe,
  input  wire logic out,
  input  wire logic pull_down,
  input  wire logic drv,
  input  wire logic drv_val,
  output logic      pad
);
  // The board drives only input-type pins.
  always_comb begin
    if (oe)
      pad = out;
    else if (drv)
      pad = drv_val;
    else
      pad = !pull_down;
  end
endmodule

// ---- dv/cps_pin_select_tb_top.sv ----
// Purpose: Self-checking bench for the pin function selector.
// Assumes: Pins boot with codes 1 and 2 from configuration.
// Notes: Pin levels are sampled on the falling edge.
`timescale 1ns/10ps
module cps_pin_select_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [3:0]  nvm_a, nvm_b;
  logic        nvm_pd, cfg, susp, chg, wr_n, rd_n, sof, unplug, vbus, inh, e;
  logic        pad_a, pad_b, a_out, a_oe, a_pd, b_out, b_oe, b_pd, drv_a, drv_b, dv_a, dv_b;
  int          bad_count, total_checks;

  cps_pin_select u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .nvm_code_a(nvm_a), .nvm_code_b(nvm_b),
    .nvm_pull_down_en(nvm_pd), .usb_configured(cfg), .usb_suspend(susp),
    .charger_detected(chg), .pin_toggle_write_strobe_n(wr_n), .pin_toggle_read_strobe_n(rd_n),
    .sof_received(sof), .cable_unplugged(unplug), .config_pin_a_in(pad_a),
    .config_pin_a_out(a_out), .config_pin_a_oe(a_oe), .config_pin_a_pull_down(a_pd),
    .config_pin_b_in(pad_b), .config_pin_b_out(b_out), .config_pin_b_oe(b_oe),
    .config_pin_b_pull_down(b_pd), .vbus_present(vbus), .suspend_inhibit(inh));
  cps_board_model u_brd_a (.oe(a_oe), .out(a_out), .pull_down(a_pd), .drv(drv_a),
    .drv_val(dv_a), .pad(pad_a));
  cps_board_model u_brd_b (.oe(b_oe), .out(b_out), .pull_down(b_pd), .drv(drv_b),
    .drv_val(dv_b), .pad(pad_b));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    do
      @(posedge pclk);
    while (pready !== 1'h1);
    rd_v = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic setc(input logic [3:0] a, input logic [3:0] b, input logic pd);
    apb(1'h1, cps_pkg::OFS_CTRL, {23'h0, pd, b, a});
    settle(4);
  endtask
  task automatic test_done();
    if (bad_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    apb(1'h0, cps_pkg::OFS_CTRL, 32'h0);
    chk(rd_v, 32'h21, "ctrl load");
    chk(32'({a_oe, pad_a, b_oe, pad_b}), 32'hE, "boot pins");
    apb(1'h0, 8'h40, 32'h0);
    chk(32'({e, rd_v[30:0]}), 32'h80000000, "unmapped read");
    apb(1'h1, cps_pkg::OFS_IRQ_MASK, 32'h5);
    apb(1'h0, cps_pkg::OFS_IRQ_MASK, 32'h0);
    chk(rd_v, 32'h5, "mask readback");
  endtask
  task automatic t_codes();
    for (int i = 0; i < 16; i++) begin
      setc(4'(i), 4'(15 - i), 1'h0);
      chk(32'(a_oe), 32'(!(i inside {0, 12, 14, 15})), "oe a");
      chk(32'(b_oe), 32'(!((15 - i) inside {0, 12, 14, 15})), "oe b");
      if (i == 1 || i == 2)
        chk(32'(pad_a), 32'(i == 1), "const a");
    end
  endtask
  task automatic t_levels(input logic [3:0] ca, input logic [3:0] cb);
    logic [1:0] v;
    setc(ca, cb, 1'h0);
    for (int i = 0; i < 4; i++) begin
      v = 2'(i);
      @(posedge pclk);
      {cfg, susp, chg, wr_n, rd_n} <= {v[0], v[1], v[0], v[0], v[1]};
      settle(3);
      if (ca == cps_pkg::FN_POWER_EN)
        chk(32'(pad_a), 32'(!(v[0] && !v[1])), "power enable");
      if (cb == cps_pkg::FN_SLEEP)
        chk(32'(pad_b), 32'(!v[1]), "sleep");
      if (ca == cps_pkg::FN_CHARGER)
        chk(32'({pad_a, pad_b}), 32'({v[0], !v[0]}), "charger");
      if (ca == cps_pkg::FN_BB_WRITE)
        chk(32'({pad_a, pad_b}), 32'({v[0], v[1]}), "strobes");
    end
    @(posedge pclk);
    {cfg, susp, wr_n, rd_n} <= 4'hB;
  endtask
  task automatic t_clk(input logic [3:0] ca, input logic [3:0] cb, input int ea, input int eb);
    int na;
    int nb;
    logic pa;
    logic pb;
    setc(ca, cb, 1'h0);
    for (int s = 0; s < 2; s++) begin
      {na, nb, pa, pb} = {32'h0, 32'h0, pad_a, pad_b};
      repeat (16) begin
        @(negedge pclk);
        na += 32'(pad_a !== pa);
        nb += 32'(pad_b !== pb);
        {pa, pb} = {pad_a, pad_b};
      end
      chk(32'(na), s ? 32'h0 : 32'(ea), "clock a");
      chk(32'(nb), s ? 32'h0 : 32'(eb), "clock b");
      @(posedge pclk);
      susp <= !susp;
      settle(4);
    end
  endtask
  task automatic t_frame();
    logic pa;
    setc(cps_pkg::FN_FRAME_TGL, cps_pkg::FN_TRISTATE, 1'h0);
    repeat (3) begin
      pa = pad_a;
      @(posedge pclk);
      sof <= 1'h1;
      @(posedge pclk);
      sof <= 1'h0;
      settle(3);
      chk(32'(pad_a), 32'(!pa), "frame toggle");
    end
  endtask
  task automatic t_vbus_irq();
    setc(cps_pkg::FN_VBUS_SENSE, cps_pkg::FN_KEEP_AWAKE, 1'h0);
    apb(1'h1, cps_pkg::OFS_IRQ_STAT, 32'hF);
    apb(1'h1, cps_pkg::OFS_IRQ_MASK, 32'h1);
    {drv_a, dv_a, drv_b, dv_b, unplug} <= 5'h15;
    settle(8);
    chk(32'({vbus, irq, inh}), 32'h3, "vbus low");
    apb(1'h1, cps_pkg::OFS_IRQ_STAT, 32'h1);
    settle(2);
    chk(32'(irq), 32'h0, "irq cleared");
    apb(1'h1, cps_pkg::OFS_IRQ_MASK, 32'h0);
    {drv_a, unplug} <= 2'h0;
    settle(8);
    chk(32'({vbus, irq, inh}), 32'h4, "vbus high masked");
    apb(1'h0, cps_pkg::OFS_IRQ_STAT, 32'h0);
    chk(rd_v, 32'h3, "vbus and keep-awake events");
    drv_b <= 1'h0;
  endtask
  task automatic t_pull();
    setc(cps_pkg::FN_TRISTATE, cps_pkg::FN_DRIVE_1, 1'h1);
    @(posedge pclk);
    susp <= 1'h1;
    settle(3);
    chk(32'({a_pd, pad_a, b_pd}), 32'h4, "pull low");
    @(posedge pclk);
    susp <= 1'h0;
    settle(3);
    chk(32'({a_pd, pad_a}), 32'h1, "pull up");
  endtask

  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {nvm_a, nvm_b, nvm_pd} = 9'h024;
    {cfg, susp, chg, sof, unplug, drv_a, drv_b, dv_a, dv_b} = '0;
    {wr_n, rd_n} = 2'h3;
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    repeat (2) @(posedge pclk);
    t_regs();
    t_codes();
    t_levels(cps_pkg::FN_POWER_EN, cps_pkg::FN_SLEEP);
    t_levels(cps_pkg::FN_CHARGER, cps_pkg::FN_CHARGER_N);
    t_levels(cps_pkg::FN_BB_WRITE, cps_pkg::FN_BB_READ);
    t_clk(cps_pkg::FN_CLK_FAST, cps_pkg::FN_CLK_SLOW, 16, 4);
    t_clk(cps_pkg::FN_CLK_MID, cps_pkg::FN_CLK_FAST, 8, 16);
    t_frame();
    t_vbus_irq();
    t_pull();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    test_done();
  end
endmodule
